/* core/gos_top.sv */
// Register decode, read path and pin drive of the eight-port output block
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "gos_consts.svh"
// Overview of operation
// - Input register reads pin levels, ignores writes
// - Output pins follow their output value bit
// - Output value registers read/write at offsets
// - Output and alias registers reset to zero
// - First port pin 0 never drives
// - Set alias write forces ones high
// - Set alias read returns output value
// - Set aliases decoded at their offsets
// - Clear alias write forces ones low
// - Clear alias read returns output value
// - Clear aliases decoded at their offsets
// - Buffer enabled only while direction bit set
module gos_top (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  srst,
	// Register port
	input  wire gos_pkg::gos_addr_type addr,
	input  wire gos_pkg::gos_byte_type wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output gos_pkg::gos_byte_type      rdata,
	// Pins
	input  wire logic [63:0]           pin_in,
	output logic [63:0]                pin_out,
	output logic [63:0]                pin_oe
);
	import gos_pkg::*;

	// ****************************************
	// Offset tables
	// ****************************************
	localparam int NP = `GOS_PORT_COUNT;
	localparam int PW = `GOS_PORT_WIDTH;
	localparam gos_addr_type DIR_OFF [NP] = '{
		`GOS_DIR_OFF_A, `GOS_DIR_OFF_B, `GOS_DIR_OFF_C, `GOS_DIR_OFF_D,
		`GOS_DIR_OFF_E, `GOS_DIR_OFF_F, `GOS_DIR_OFF_G, `GOS_DIR_OFF_H};
	localparam gos_addr_type DIN_OFF [NP] = '{
		`GOS_DIN_OFF_A, `GOS_DIN_OFF_B, `GOS_DIN_OFF_C, `GOS_DIN_OFF_D,
		`GOS_DIN_OFF_E, `GOS_DIN_OFF_F, `GOS_DIN_OFF_G, `GOS_DIN_OFF_H};
	localparam gos_addr_type DOUT_OFF [NP] = '{
		`GOS_DOUT_OFF_A, `GOS_DOUT_OFF_B, `GOS_DOUT_OFF_C, `GOS_DOUT_OFF_D,
		`GOS_DOUT_OFF_E, `GOS_DOUT_OFF_F, `GOS_DOUT_OFF_G, `GOS_DOUT_OFF_H};
	localparam gos_addr_type SET_OFF [NP] = '{
		`GOS_SET_OFF_A, `GOS_SET_OFF_B, `GOS_SET_OFF_C, `GOS_SET_OFF_D,
		`GOS_SET_OFF_E, `GOS_SET_OFF_F, `GOS_SET_OFF_G, `GOS_SET_OFF_H};
	localparam gos_addr_type CLR_OFF [NP] = '{
		`GOS_CLR_OFF_A, `GOS_CLR_OFF_B, `GOS_CLR_OFF_C, `GOS_CLR_OFF_D,
		`GOS_CLR_OFF_E, `GOS_CLR_OFF_F, `GOS_CLR_OFF_G, `GOS_CLR_OFF_H};

	// ****************************************
	// Per-port registers and synchronisers
	// ****************************************
	gos_byte_type      dout_v  [NP];
	gos_byte_type      dir_v   [NP];
	gos_byte_type      level_v [NP];
	gos_top_state_type state_r;
	gos_top_state_type state_nxt;
	logic [NP-1:0]     wr_dir_hit;
	logic [NP-1:0]     wr_dout_hit;
	logic [NP-1:0]     wr_set_hit;
	logic [NP-1:0]     wr_clr_hit;

	// ****************************************
	// Write decode
	// ****************************************
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			wr_dir_hit[p]  = wr && (addr == DIR_OFF[p]);
			wr_dout_hit[p] = wr && (addr == DOUT_OFF[p]);
			wr_set_hit[p]  = wr && (addr == SET_OFF[p]);
			wr_clr_hit[p]  = wr && (addr == CLR_OFF[p]);
		end
	end

	// ****************************************
	// Port A
	// ****************************************
	gos_port #(
		.LOCK_PIN0 (1'b1)
	) u_port_a (
		.clock   (clock),
		.srst    (srst),
		.wr_dir  (wr_dir_hit[0]),
		.wr_dout (wr_dout_hit[0]),
		.wr_set  (wr_set_hit[0]),
		.wr_clr  (wr_clr_hit[0]),
		.wdata   (wdata),
		.dout    (dout_v[0]),
		.dir     (dir_v[0])
	);

	gos_sync u_sync_a (
		.clock     (clock),
		.srst      (srst),
		.pin_raw   (pin_in[0*PW +: PW]),
		.pin_level (level_v[0])
	);

	// ****************************************
	// Port B
	// ****************************************
	gos_port #(
		.LOCK_PIN0 (1'b0)
	) u_port_b (
		.clock   (clock),
		.srst    (srst),
		.wr_dir  (wr_dir_hit[1]),
		.wr_dout (wr_dout_hit[1]),
		.wr_set  (wr_set_hit[1]),
		.wr_clr  (wr_clr_hit[1]),
		.wdata   (wdata),
		.dout    (dout_v[1]),
		.dir     (dir_v[1])
	);

	gos_sync u_sync_b (
		.clock     (clock),
		.srst      (srst),
		.pin_raw   (pin_in[1*PW +: PW]),
		.pin_level (level_v[1])
	);

	// ****************************************
	// Port C
	// ****************************************
	gos_port #(
		.LOCK_PIN0 (1'b0)
	) u_port_c (
		.clock   (clock),
		.srst    (srst),
		.wr_dir  (wr_dir_hit[2]),
		.wr_dout (wr_dout_hit[2]),
		.wr_set  (wr_set_hit[2]),
		.wr_clr  (wr_clr_hit[2]),
		.wdata   (wdata),
		.dout    (dout_v[2]),
		.dir     (dir_v[2])
	);

	gos_sync u_sync_c (
		.clock     (clock),
		.srst      (srst),
		.pin_raw   (pin_in[2*PW +: PW]),
		.pin_level (level_v[2])
	);

	// ****************************************
	// Port D
	// ****************************************
	gos_port #(
		.LOCK_PIN0 (1'b0)
	) u_port_d (
		.clock   (clock),
		.srst    (srst),
		.wr_dir  (wr_dir_hit[3]),
		.wr_dout (wr_dout_hit[3]),
		.wr_set  (wr_set_hit[3]),
		.wr_clr  (wr_clr_hit[3]),
		.wdata   (wdata),
		.dout    (dout_v[3]),
		.dir     (dir_v[3])
	);

	gos_sync u_sync_d (
		.clock     (clock),
		.srst      (srst),
		.pin_raw   (pin_in[3*PW +: PW]),
		.pin_level (level_v[3])
	);

	// ****************************************
	// Port E
	// ****************************************
	gos_port #(
		.LOCK_PIN0 (1'b0)
	) u_port_e (
		.clock   (clock),
		.srst    (srst),
		.wr_dir  (wr_dir_hit[4]),
		.wr_dout (wr_dout_hit[4]),
		.wr_set  (wr_set_hit[4]),
		.wr_clr  (wr_clr_hit[4]),
		.wdata   (wdata),
		.dout    (dout_v[4]),
		.dir     (dir_v[4])
	);

	gos_sync u_sync_e (
		.clock     (clock),
		.srst      (srst),
		.pin_raw   (pin_in[4*PW +: PW]),
		.pin_level (level_v[4])
	);

	// ****************************************
	// Port F
	// ****************************************
	gos_port #(
		.LOCK_PIN0 (1'b0)
	) u_port_f (
		.clock   (clock),
		.srst    (srst),
		.wr_dir  (wr_dir_hit[5]),
		.wr_dout (wr_dout_hit[5]),
		.wr_set  (wr_set_hit[5]),
		.wr_clr  (wr_clr_hit[5]),
		.wdata   (wdata),
		.dout    (dout_v[5]),
		.dir     (dir_v[5])
	);

	gos_sync u_sync_f (
		.clock     (clock),
		.srst      (srst),
		.pin_raw   (pin_in[5*PW +: PW]),
		.pin_level (level_v[5])
	);

	// ****************************************
	// Port G
	// ****************************************
	gos_port #(
		.LOCK_PIN0 (1'b0)
	) u_port_g (
		.clock   (clock),
		.srst    (srst),
		.wr_dir  (wr_dir_hit[6]),
		.wr_dout (wr_dout_hit[6]),
		.wr_set  (wr_set_hit[6]),
		.wr_clr  (wr_clr_hit[6]),
		.wdata   (wdata),
		.dout    (dout_v[6]),
		.dir     (dir_v[6])
	);

	gos_sync u_sync_g (
		.clock     (clock),
		.srst      (srst),
		.pin_raw   (pin_in[6*PW +: PW]),
		.pin_level (level_v[6])
	);

	// ****************************************
	// Port H
	// ****************************************
	gos_port #(
		.LOCK_PIN0 (1'b0)
	) u_port_h (
		.clock   (clock),
		.srst    (srst),
		.wr_dir  (wr_dir_hit[7]),
		.wr_dout (wr_dout_hit[7]),
		.wr_set  (wr_set_hit[7]),
		.wr_clr  (wr_clr_hit[7]),
		.wdata   (wdata),
		.dout    (dout_v[7]),
		.dir     (dir_v[7])
	);

	gos_sync u_sync_h (
		.clock     (clock),
		.srst      (srst),
		.pin_raw   (pin_in[7*PW +: PW]),
		.pin_level (level_v[7])
	);

	// ****************************************
	// Pin drive
	// ****************************************
	assign pin_out = {dout_v[7], dout_v[6], dout_v[5], dout_v[4],
		dout_v[3], dout_v[2], dout_v[1], dout_v[0]};
	assign pin_oe  = {dir_v[7], dir_v[6], dir_v[5], dir_v[4],
		dir_v[3], dir_v[2], dir_v[1], dir_v[0]};

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		state_nxt         = state_r;
		state_nxt.rdata_r = `GOS_READ_IDLE;
		if (rd) begin
			case (addr)
				// Direction
				DIR_OFF[0]: state_nxt.rdata_r = dir_v[0];
				DIR_OFF[1]: state_nxt.rdata_r = dir_v[1];
				DIR_OFF[2]: state_nxt.rdata_r = dir_v[2];
				DIR_OFF[3]: state_nxt.rdata_r = dir_v[3];
				DIR_OFF[4]: state_nxt.rdata_r = dir_v[4];
				DIR_OFF[5]: state_nxt.rdata_r = dir_v[5];
				DIR_OFF[6]: state_nxt.rdata_r = dir_v[6];
				DIR_OFF[7]: state_nxt.rdata_r = dir_v[7];

				// Input levels
				DIN_OFF[0]: state_nxt.rdata_r = level_v[0];
				DIN_OFF[1]: state_nxt.rdata_r = level_v[1];
				DIN_OFF[2]: state_nxt.rdata_r = level_v[2];
				DIN_OFF[3]: state_nxt.rdata_r = level_v[3];
				DIN_OFF[4]: state_nxt.rdata_r = level_v[4];
				DIN_OFF[5]: state_nxt.rdata_r = level_v[5];
				DIN_OFF[6]: state_nxt.rdata_r = level_v[6];
				DIN_OFF[7]: state_nxt.rdata_r = level_v[7];

				// Output values
				DOUT_OFF[0]: state_nxt.rdata_r = dout_v[0];
				DOUT_OFF[1]: state_nxt.rdata_r = dout_v[1];
				DOUT_OFF[2]: state_nxt.rdata_r = dout_v[2];
				DOUT_OFF[3]: state_nxt.rdata_r = dout_v[3];
				DOUT_OFF[4]: state_nxt.rdata_r = dout_v[4];
				DOUT_OFF[5]: state_nxt.rdata_r = dout_v[5];
				DOUT_OFF[6]: state_nxt.rdata_r = dout_v[6];
				DOUT_OFF[7]: state_nxt.rdata_r = dout_v[7];

				// Set aliases
				SET_OFF[0]: state_nxt.rdata_r = dout_v[0];
				SET_OFF[1]: state_nxt.rdata_r = dout_v[1];
				SET_OFF[2]: state_nxt.rdata_r = dout_v[2];
				SET_OFF[3]: state_nxt.rdata_r = dout_v[3];
				SET_OFF[4]: state_nxt.rdata_r = dout_v[4];
				SET_OFF[5]: state_nxt.rdata_r = dout_v[5];
				SET_OFF[6]: state_nxt.rdata_r = dout_v[6];
				SET_OFF[7]: state_nxt.rdata_r = dout_v[7];

				// Clear aliases
				CLR_OFF[0]: state_nxt.rdata_r = dout_v[0];
				CLR_OFF[1]: state_nxt.rdata_r = dout_v[1];
				CLR_OFF[2]: state_nxt.rdata_r = dout_v[2];
				CLR_OFF[3]: state_nxt.rdata_r = dout_v[3];
				CLR_OFF[4]: state_nxt.rdata_r = dout_v[4];
				CLR_OFF[5]: state_nxt.rdata_r = dout_v[5];
				CLR_OFF[6]: state_nxt.rdata_r = dout_v[6];
				CLR_OFF[7]: state_nxt.rdata_r = dout_v[7];
				default: state_nxt.rdata_r = `GOS_READ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign rdata = state_r.rdata_r;

endmodule : gos_top

/* core/gos_consts.svh */
// Offsets, reset values and sizes of the output set/clear block
`ifndef GOS_CONSTS_SVH
`define GOS_CONSTS_SVH

// ****************************************
// Sizes and reset values
// ****************************************
`define GOS_PORT_COUNT  8
`define GOS_PORT_WIDTH  8
`define GOS_ADDR_WIDTH  8
`define GOS_RESET_VAL   8'h00
`define GOS_READ_IDLE   8'h00
`define GOS_LOCKED_PIN  0

// ****************************************
// Direction offsets
// ****************************************
`define GOS_DIR_OFF_A   8'h24
`define GOS_DIR_OFF_B   8'h38
`define GOS_DIR_OFF_C   8'h4C
`define GOS_DIR_OFF_D   8'h60
`define GOS_DIR_OFF_E   8'h74
`define GOS_DIR_OFF_F   8'h88
`define GOS_DIR_OFF_G   8'h9C
`define GOS_DIR_OFF_H   8'hB0

// ****************************************
// Input level offsets
// ****************************************
`define GOS_DIN_OFF_A   8'h28
`define GOS_DIN_OFF_B   8'h3C
`define GOS_DIN_OFF_C   8'h50
`define GOS_DIN_OFF_D   8'h64
`define GOS_DIN_OFF_E   8'h78
`define GOS_DIN_OFF_F   8'h8C
`define GOS_DIN_OFF_G   8'hA0
`define GOS_DIN_OFF_H   8'hB4

// ****************************************
// Output value offsets
// ****************************************
`define GOS_DOUT_OFF_A  8'h2C
`define GOS_DOUT_OFF_B  8'h40
`define GOS_DOUT_OFF_C  8'h54
`define GOS_DOUT_OFF_D  8'h68
`define GOS_DOUT_OFF_E  8'h7C
`define GOS_DOUT_OFF_F  8'h90
`define GOS_DOUT_OFF_G  8'hA4
`define GOS_DOUT_OFF_H  8'hB8

// ****************************************
// Set alias offsets
// ****************************************
`define GOS_SET_OFF_A   8'h30
`define GOS_SET_OFF_B   8'h44
`define GOS_SET_OFF_C   8'h58
`define GOS_SET_OFF_D   8'h6C
`define GOS_SET_OFF_E   8'h80
`define GOS_SET_OFF_F   8'h9F
`define GOS_SET_OFF_G   8'hA8
`define GOS_SET_OFF_H   8'hBC

// ****************************************
// Clear alias offsets
// ****************************************
`define GOS_CLR_OFF_A   8'h34
`define GOS_CLR_OFF_B   8'h48
`define GOS_CLR_OFF_C   8'h5C
`define GOS_CLR_OFF_D   8'h70
`define GOS_CLR_OFF_E   8'h84
`define GOS_CLR_OFF_F   8'h98
`define GOS_CLR_OFF_G   8'hAC
`define GOS_CLR_OFF_H   8'hC0

`endif

/* core/gos_pkg.sv */
// Types shared by the output set/clear block
package gos_pkg;

// ****************************************
// Types
// ****************************************
typedef logic [7:0] gos_byte_type;
typedef logic [7:0] gos_addr_type;

typedef struct packed {
	logic [7:0] dout_r;
	logic [7:0] dir_r;
} gos_port_state_type;

typedef struct packed {
	logic [7:0] meta_r;
	logic [7:0] level_r;
} gos_sync_state_type;

typedef struct packed {
	logic [7:0] rdata_r;
} gos_top_state_type;

endpackage : gos_pkg

/* core/gos_sync.sv */
// Two-stage synchroniser for one port of input pins
`timescale 1ns/1ps
module gos_sync (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             srst,
	// Pins and synchronised level
	input  wire gos_pkg::gos_byte_type pin_raw,
	output gos_pkg::gos_byte_type      pin_level
);
	import gos_pkg::*;

	gos_sync_state_type state_r;
	gos_sync_state_type state_nxt;

	always_comb begin
		state_nxt         = state_r;
		state_nxt.meta_r  = pin_raw;
		state_nxt.level_r = state_r.meta_r;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign pin_level = state_r.level_r;

endmodule : gos_sync

/* core/gos_port.sv */
// Direction and output value registers of one port
`timescale 1ns/1ps
`include "gos_consts.svh"
module gos_port #(
	parameter bit LOCK_PIN0 = 1'b0
) (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  srst,
	// Decoded write strobes
	input  wire logic                  wr_dir,
	input  wire logic                  wr_dout,
	input  wire logic                  wr_set,
	input  wire logic                  wr_clr,
	input  wire gos_pkg::gos_byte_type wdata,
	// Register contents
	output gos_pkg::gos_byte_type      dout,
	output gos_pkg::gos_byte_type      dir
);
	import gos_pkg::*;

	gos_port_state_type state_r;
	gos_port_state_type state_nxt;

	always_comb begin
		state_nxt = state_r;
		if (wr_dir) begin
			state_nxt.dir_r = wdata;
		end
		if (wr_dout) begin
			state_nxt.dout_r = wdata;
		end
		if (wr_set) begin
			state_nxt.dout_r = state_r.dout_r | wdata;
		end
		if (wr_clr) begin
			state_nxt.dout_r = state_r.dout_r & ~wdata;
		end
		if (LOCK_PIN0) begin
			state_nxt.dout_r[`GOS_LOCKED_PIN] = 1'b0;
			state_nxt.dir_r[`GOS_LOCKED_PIN]  = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_r.dout_r <= `GOS_RESET_VAL;
			state_r.dir_r  <= `GOS_RESET_VAL;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign dout = state_r.dout_r;
	assign dir  = state_r.dir_r;

endmodule : gos_port

/* dv/gos_top_sva.sv */
// Port-level assertions of the output set/clear block
`timescale 1ns/1ps
module gos_top_sva (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  srst,
	// Register port
	input  wire gos_pkg::gos_addr_type addr,
	input  wire gos_pkg::gos_byte_type wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	input  wire gos_pkg::gos_byte_type rdata,
	// Pins
	input  wire logic [63:0]           pin_out,
	input  wire logic [63:0]           pin_oe
);
	import gos_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	// ****
	// Checks
	// ****
	chk_pa0_frozen: assert property (pin_out[0] == 1'b0 && pin_oe[0] == 1'b0)
		else $error("port A pin 0 driven");
	chk_set_port_a: assert property (wr && addr == 8'h30 |=>
		pin_out[7:1] == ($past(pin_out[7:1]) | $past(wdata[7:1])))
		else $error("set alias of port A wrong");
	chk_clr_port_h: assert property (wr && addr == 8'hC0 |=>
		pin_out[63:56] == ($past(pin_out[63:56]) & ~$past(wdata)))
		else $error("clear alias of port H wrong");
	chk_value_h: assert property (wr && addr == 8'hB8 |=> pin_out[63:56] == $past(wdata))
		else $error("value write of port H wrong");
	chk_dir_port_a: assert property (wr && addr == 8'h24 |=>
		pin_oe[7:0] == {$past(wdata[7:1]), 1'b0})
		else $error("direction of port A wrong");
	chk_input_write: assert property (wr && addr == 8'h28 |=> $stable(pin_out) && $stable(pin_oe))
		else $error("input write changed outputs");
	chk_set_read: assert property (rd && addr == 8'h30 |=>
		rdata == $past(pin_out[7:0]) && $stable(pin_out))
		else $error("set alias read wrong");
	chk_clr_read: assert property (rd && addr == 8'h48 |=>
		rdata == $past(pin_out[15:8]) && $stable(pin_out))
		else $error("clear alias read wrong");
	chk_reset_zero: assert property (disable iff (1'b0) srst |=>
		pin_out == 64'h0 && pin_oe == 64'h0 && rdata == 8'h00)
		else $error("outputs not zero after reset");
endmodule : gos_top_sva

/* dv/tb_top.sv */
// Testbench of the output set/clear block
`timescale 1ns/1ps
module tb_top;
	import gos_pkg::*;
	logic         clock      = 1'b0;
	logic         srst       = 1'b1;
	gos_addr_type addr       = 8'h00;
	gos_byte_type wdata      = 8'h00;
	logic         wr         = 1'b0;
	logic         rd         = 1'b0;
	logic [63:0]  pin_in     = 64'h0;
	gos_byte_type rdata;
	logic [63:0]  pin_out;
	logic [63:0]  pin_oe;
	int           num_errors = 0;
	int           tests_run  = 0;
	gos_addr_type dir_off[8] = '{8'h24, 8'h38, 8'h4C, 8'h60, 8'h74, 8'h88, 8'h9C, 8'hB0};
	gos_addr_type din_off[8] = '{8'h28, 8'h3C, 8'h50, 8'h64, 8'h78, 8'h8C, 8'hA0, 8'hB4};
	gos_addr_type val_off[8] = '{8'h2C, 8'h40, 8'h54, 8'h68, 8'h7C, 8'h90, 8'hA4, 8'hB8};
	gos_addr_type set_off[8] = '{8'h30, 8'h44, 8'h58, 8'h6C, 8'h80, 8'h9F, 8'hA8, 8'hBC};
	gos_addr_type clr_off[8] = '{8'h34, 8'h48, 8'h5C, 8'h70, 8'h84, 8'h98, 8'hAC, 8'hC0};
	always #12.5 clock = ~clock;
	gos_top dut (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
	// ****
	// Shared tasks
	// ****
	task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task wr_reg(input gos_addr_type a, input gos_byte_type d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_chk(input gos_addr_type a, input gos_byte_type e);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		check($sformatf("rdata at %h", a), {56'h0, rdata}, {56'h0, e});
		@(posedge clock);
	endtask : rd_chk
	// ****
	// Scenarios
	// ****
	task t_reset_values;
		check("pin_out", pin_out, 64'h0);
		check("pin_oe", pin_oe, 64'h0);
		for (int p = 0; p < 8; p++) begin
			rd_chk(val_off[p], 8'h00);
			rd_chk(set_off[p], 8'h00);
			rd_chk(clr_off[p], 8'h00);
		end
	endtask : t_reset_values
	task t_value_dir;
		gos_byte_type m;
		for (int p = 0; p < 8; p++) begin
			m = (p == 0) ? 8'hFE : 8'hFF;
			wr_reg(val_off[p], 8'hA5);
			@(posedge clock);
			wr_reg(dir_off[p], 8'hFF);
			rd_chk(val_off[p], 8'hA5 & m);
			check("pin_out port", {56'h0, pin_out[p*8+:8]}, {56'h0, 8'hA5 & m});
			check("pin_oe port", {56'h0, pin_oe[p*8+:8]}, {56'h0, m});
		end
	endtask : t_value_dir
	task t_set_clear;
		for (int p = 0; p < 8; p++) begin
			wr_reg(set_off[p], 8'h5B);
			rd_chk(set_off[p], (p == 0) ? 8'hFE : 8'hFF);
			wr_reg(clr_off[p], 8'h0F);
			rd_chk(clr_off[p], 8'hF0);
			rd_chk(val_off[p], 8'hF0);
			wr_reg(set_off[p], 8'h03);
			rd_chk(clr_off[p], (p == 0) ? 8'hF2 : 8'hF3);
			wr_reg(clr_off[p], 8'h03);
			rd_chk(set_off[p], 8'hF0);
		end
	endtask : t_set_clear
	task t_input;
		pin_in <= 64'h0123456789ABCDEF;
		repeat (3) @(posedge clock);
		for (int p = 0; p < 8; p++)
			rd_chk(din_off[p], pin_in[p*8+:8]);
		wr_reg(din_off[0], 8'h00);
		rd_chk(din_off[0], 8'hEF);
		wr_reg(8'h94, 8'hFF);
		rd_chk(8'h94, 8'h00);
		check("pin_out", pin_out, {8{8'hF0}});
	endtask : t_input
	task t_mid_reset;
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		check("pin_out after reset", pin_out, 64'h0);
		check("pin_oe after reset", pin_oe, 64'h0);
		rd_chk(val_off[7], 8'h00);
		rd_chk(set_off[5], 8'h00);
		rd_chk(clr_off[2], 8'h00);
	endtask : t_mid_reset
	initial begin
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		t_reset_values;
		t_value_dir;
		t_set_clear;
		t_input;
		t_mid_reset;
		test_done;
	end
	initial begin
		repeat (3000) @(posedge clock);
		num_errors++;
		test_done;
	end
endmodule : tb_top
bind gos_top gos_top_sva chk (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .pin_out(pin_out), .pin_oe(pin_oe));
